// ---- logic/rcal_pkg.sv ----
package rcal_pkg;
  localparam logic [2:0] RCAL_CTRL_ADDR = 3'h7;
  localparam int RCAL_MAG_LSB = 0;
  localparam int RCAL_MAG_W = 5;
  localparam int RCAL_SIGN_BIT = 5;
  localparam int RCAL_FT_BIT = 6;
  localparam int RCAL_OUT_BIT = 7;
  // Power-on: test off, level high; other bits arbitrary, zero here
  localparam logic [7:0] RCAL_CTRL_RESET = 8'h80;
  localparam int RCAL_OSC_HZ = 32768;
  localparam int RCAL_TEST_HZ = 512;
  localparam int RCAL_TEST_HALF = RCAL_OSC_HZ / (2 * RCAL_TEST_HZ);
  localparam int RCAL_STAGE_DIV = 256;
  localparam int RCAL_ADD_CYC = 128;
  localparam int RCAL_SUB_CYC = 256;
  localparam int RCAL_SEC_PER_MIN = 60;
  localparam int RCAL_CYCLE_MIN = 64;
  localparam int RCAL_ELIG_MIN = 62;
endpackage

// ---- logic/rcal_test_div.sv ----
`timescale 1ns/100ps
`default_nettype none
// Free-running divider ahead of the correction logic
module rcal_test_div
  import rcal_pkg::*;
#(
  parameter int HALF = RCAL_TEST_HALF
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  output logic wave
);
  logic [15:0] cnt_r;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cnt_r <= 16'h0000;
      wave <= 1'b0;
    end else if (cnt_r == 16'(HALF - 1)) begin
      cnt_r <= 16'h0000;
      wave <= ~wave;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ---- logic/rcal_core.sv ----
`timescale 1ns/100ps
`default_nettype none
module rcal_core
  import rcal_pkg::*;
#(
  parameter int SEC_PER_MIN = RCAL_SEC_PER_MIN
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic sec_tick,
  output logic [5:0] cycle_minute,
  output logic shared_test_level_pin_o,
  output logic shared_test_level_pin_oe
);
  // sys_clk stands for the oscillator: one edge per oscillator cycle
  localparam logic [15:0] NOM = 16'(RCAL_OSC_HZ - 1);
  localparam logic [15:0] SHORT = 16'(RCAL_OSC_HZ - RCAL_ADD_CYC - 1);
  localparam logic [15:0] LONG = 16'(RCAL_OSC_HZ + RCAL_SUB_CYC - 1);
  localparam logic [7:0] STAGE_TOP = 8'(RCAL_STAGE_DIV - 1);

  logic [7:0] ctrl_r;
  logic [15:0] osc_cnt_r;
  logic [7:0] stage_r;
  logic [5:0] sec_r;
  logic [5:0] min_r;
  logic corr_done_r;
  logic test_wave;
  logic [4:0] mag;
  logic active;
  logic [15:0] sec_len;
  logic sec_end;

  assign mag = ctrl_r[RCAL_MAG_LSB +: RCAL_MAG_W];
  // Bit 0 of the minute is dropped: N covers minutes 0..2N-1
  assign active = (mag != 5'h00) && (min_r[5:1] < mag)
    && (min_r < 6'(RCAL_ELIG_MIN)) && !corr_done_r;
  always_comb begin
    sec_len = NOM;
    if (active) begin
      sec_len = ctrl_r[RCAL_SIGN_BIT] ? SHORT : LONG;
    end
  end
  assign sec_end = (osc_cnt_r == sec_len);

  // Control register, independent of timekeeping
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ctrl_r <= RCAL_CTRL_RESET;
    end else if (reg_wr && reg_addr == RCAL_CTRL_ADDR) begin
      ctrl_r <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= (reg_addr == RCAL_CTRL_ADDR) ? ctrl_r : 8'h00;
    end
  end

  // Prescaler position kept for visibility of the 256 stage
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      stage_r <= 8'h00;
    end else if (sec_end || stage_r == STAGE_TOP) begin
      stage_r <= 8'h00;
    end else begin
      stage_r <= stage_r + 8'h01;
    end
  end

  // Seconds length grows by one whole 256-stage count (LONG) or shrinks by half of one (SHORT)
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      osc_cnt_r <= 16'h0000;
      sec_tick <= 1'b0;
    end else begin
      sec_tick <= sec_end;
      osc_cnt_r <= sec_end ? 16'h0000 : osc_cnt_r + 16'h0001;
    end
  end

  // Minute and 64-minute cycle position
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sec_r <= 6'h00;
      min_r <= 6'h00;
      corr_done_r <= 1'b0;
    end else if (sec_end) begin
      if (sec_r == 6'(SEC_PER_MIN - 1)) begin
        sec_r <= 6'h00;
        min_r <= min_r + 6'h01;
        corr_done_r <= 1'b0;
      end else begin
        sec_r <= sec_r + 6'h01;
        // Only one second per minute is altered
        if (active) corr_done_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cycle_minute <= 6'h00;
    end else begin
      cycle_minute <= min_r;
    end
  end

  rcal_test_div u_div (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .wave(test_wave)
  );

  // Open drain: only drive low, release for high
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      shared_test_level_pin_o <= 1'b0;
      shared_test_level_pin_oe <= 1'b0;
    end else begin
      shared_test_level_pin_o <= 1'b0;
      if (ctrl_r[RCAL_FT_BIT]) begin
        shared_test_level_pin_oe <= ~test_wave;
      end else begin
        shared_test_level_pin_oe <= ~ctrl_r[RCAL_OUT_BIT];
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/rcal_pullup.sv ----
`timescale 1ns/100ps
`default_nettype none
// Board pull-up: a released line reads high
module rcal_pullup (input wire logic oe, o, output logic pin);
  assign pin = oe ? o : 1'b1;
endmodule
`default_nettype wire

// ---- testbench/rcal_core_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module rcal_core_monitor (
  input wire logic sys_clk, reset_n, reg_wr, sec_tick,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata,
  input wire logic [5:0] cycle_minute,
  input wire logic shared_test_level_pin_o, shared_test_level_pin_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_wr_ctl; reg_wr && reg_addr == 3'h7; endsequence
  sequence s_rd_ctl; !reg_wr && reg_addr == 3'h7; endsequence
  a_drain_only: assert property (!shared_test_level_pin_o)
    else $error("pin driven high");
  a_level_follows: assert property ((s_wr_ctl ##0 !reg_wdata[6])
    ##1 !reg_wr [*2] |=>
    shared_test_level_pin_oe == !$past(reg_wdata[7], 3))
    else $error("pin level wrong");
  a_power_on: assert property ($rose(reset_n) |->
    !shared_test_level_pin_oe && reg_rdata == 8'h00) else $error("bad reset");
  a_read_back: assert property (s_wr_ctl ##1 s_rd_ctl |=>
    reg_rdata == $past(reg_wdata, 2)) else $error("bad read back");
  a_read_hold: assert property (s_rd_ctl [*2] |=> $stable(reg_rdata))
    else $error("read data moved");
  a_unmapped_zero: assert property (reg_addr != 3'h7 |=>
    reg_rdata == 8'h00) else $error("unmapped read");
  a_tick_single: assert property (sec_tick |=> !sec_tick [*8])
    else $error("long tick");
  a_minute_step: assert property ($changed(cycle_minute) |->
    cycle_minute == $past(cycle_minute) + 6'h01) else $error("minute skip");
endmodule
bind rcal_core rcal_core_monitor i_mon (.*);
`default_nettype wire

// ---- testbench/test_rcal_core.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_rcal_core import rcal_pkg::*; ;
  logic sys_clk = 0, reset_n = 0, reg_wr = 0, sec_tick, pin;
  logic shared_test_level_pin_o, shared_test_level_pin_oe;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, ctl, d;
  logic [7:0] cal_q[$] = '{8'h01, 8'h22};
  logic [5:0] cycle_minute;
  int fail_count = 0, n_compared = 0, m, t;
  // One-second minutes keep the run near three seconds
  rcal_core #(.SEC_PER_MIN(1)) i_rcal_core (.*);
  rcal_pullup i_rcal_pullup (.oe(shared_test_level_pin_oe),
    .o(shared_test_level_pin_o), .pin);
  always #2 sys_clk = ~sys_clk;
  // Three seconds of oscillator cycles plus margin
  initial #400us stop_test(1);
  task automatic chk(logic [15:0] got, exp);
    n_compared++;
    fail_count += 32'(got !== exp);
    if (got !== exp) $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
  endtask
  task automatic bus(logic [2:0] a, logic [7:0] v, bit w);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= w;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1 d = reg_rdata;
    if (w && a == 3'h7) ctl = v;
  endtask
  task automatic gap(bit tick);
    logic p = pin;
    t = 0;
    do @(posedge sys_clk) #1 t++;
    while (tick ? !sec_tick : pin === p);
  endtask
  function automatic int exp_len(logic [7:0] c, int mn);
    return RCAL_OSC_HZ + (mn < RCAL_ELIG_MIN && mn / 2 < c[4:0] ?
      (c[5] ? -RCAL_ADD_CYC : RCAL_SUB_CYC) : 0);
  endfunction
  task automatic stop_test(int late);
    fail_count += late;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h6DFD));
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    bus(3'h7, 8'h00, 0);
    chk(d[7:6], 2'h2);
    chk(pin, 1'b1);
    for (m = 0; m < 4; m++) begin
      bus(3'h7, {m[1:0], 6'($urandom)}, 1);
      bus(3'h7, 8'h00, 0);
      chk(d, ctl);
      if (ctl[6]) gap(0);
      if (ctl[6]) gap(0);
      chk(ctl[6] ? t : pin, ctl[6] ? RCAL_TEST_HALF : ctl[7]);
      bus(3'($urandom % 7), 8'($urandom), 1);
      bus(reg_addr, 8'h00, 0);
      chk(d, 8'h00);
    end
    bus(3'h7, 8'h00, 0);
    chk(d, ctl);
    gap(1);
    // Change only just after a tick so each second sees one setting
    for (m = 1; m < 3; m++) begin
      bus(3'h7, cal_q.pop_front(), 1);
      chk(cycle_minute, 6'(m));
      gap(1);
      chk(t + 2, exp_len(ctl, m));
    end
    stop_test(0);
  end
endmodule
`default_nettype wire
